// File: verilog/urt_pkg.sv
/*
 * Constants, register map and carrier types of the receive-timeout and
 * FIFO DMA trigger block. Assumes a 40 MHz clock and one register master.
 */
// Functional notes
// R1: Timeout counter reloads from high/low registers.
// R2: Feature register two bit 6 selects periodic.
// R3: Ident register read clears pending timeout.
// R4: Original mode: pending data retriggers timeout.
// R5: Periodic mode: every expiry raises timeout again.
// R6: DMA receive use needs periodic mode.
// R7: DMA trigger levels only powers of two; the code accepts any level and treats zero as one.
// R8: Holding/modem/line status reads leave timeout alone.
package urt_pkg;
    localparam int          DATA_W  = 16;
    localparam int          ADDR_W  = 4;
    localparam int          PTR_W   = 5;
    localparam int          CNT_W   = 6;
    localparam int          BYTE_W  = 8;
    localparam logic [5:0]  FIFO_DEPTH = 6'h20;

    // Register indices on the plain port
    localparam logic [3:0]  A_RX_HOLDING  = 4'h0;
    localparam logic [3:0]  A_IRQ_IDENT   = 4'h1;
    localparam logic [3:0]  A_TRIG_LEVEL  = 4'h2;
    localparam logic [3:0]  A_FEATURE_TWO = 4'h3;
    localparam logic [3:0]  A_TO_LOW      = 4'h4;
    localparam logic [3:0]  A_TO_HIGH     = 4'h5;
    localparam logic [3:0]  A_LINE_STAT   = 4'h6;
    localparam logic [3:0]  A_MODEM_STAT  = 4'h7;
    localparam logic [3:0]  A_IRQ_STAT    = 4'h8;
    localparam logic [3:0]  A_IRQ_MASK    = 4'h9;

    // Field positions
    localparam int          PERIODIC_BIT = 6;
    localparam int          IIR_NONE_BIT = 0;
    localparam int          IIR_TO_BIT   = 1;
    localparam int          LSR_DR_BIT   = 0;
    localparam int          LSR_OE_BIT   = 1;
    localparam int          TLR_RX_LSB   = 8;
    localparam int          ST_TIMEOUT   = 0;
    localparam int          ST_RX_TRIG   = 1;
    localparam int          ST_TX_TRIG   = 2;
    localparam int          ST_OVERRUN   = 3;
    localparam int          N_EVENTS     = 4;

    // Reset values and limits
    localparam logic [7:0]  TO_RESET     = 8'h00;
    localparam logic [15:0] TLR_RESET    = 16'h0101;
    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic [5:0]  LEVEL_MIN    = 6'h01;
    localparam logic [15:0] TO_LAST      = 16'h0001;

    // Timeout counts in microsecond units
    localparam int          CLK_PERIOD_NS = 25;
    localparam int          TO_UNIT_NS    = 1000;
    localparam logic [5:0]  TICK_CYC      = 6'(TO_UNIT_NS / CLK_PERIOD_NS);

    typedef struct packed {
        logic                wr;
        logic                rd;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
    } urt_bus_req_t;
endpackage : urt_pkg

// File: verilog/urt_fifo_mem.sv
/*
 * Receive FIFO storage, 32 bytes, one write and one registered read port.
 * Assumes the caller presents the read address of the next cycle.
 */
`timescale 1ns/1ps
module urt_fifo_mem (
    // Clock
    input  wire logic                          clk_i,
    // Write port
    input  wire logic                          we_i,
    input  wire logic [urt_pkg::PTR_W-1:0]     waddr_i,
    input  wire logic [urt_pkg::BYTE_W-1:0]    wdata_i,
    // Read port
    input  wire logic [urt_pkg::PTR_W-1:0]     raddr_i,
    output logic      [urt_pkg::BYTE_W-1:0]    rdata_o
);
    import urt_pkg::*;

    logic [BYTE_W-1:0] mem_q [int'(FIFO_DEPTH)];

    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
    end

    // Bypass so a byte written now is readable next cycle
    always_ff @(posedge clk_i) begin
        if (we_i && (waddr_i == raddr_i)) begin
            rdata_o <= wdata_i;
        end else begin
            rdata_o <= mem_q[raddr_i];
        end
    end
endmodule : urt_fifo_mem

// File: verilog/urt_rx_timeout_dma.sv
/*
 * Receive timeout, interrupt and FIFO DMA trigger logic of a serial port.
 * Assumes a byte receiver and a transmit FIFO on the same clock.
 */
`timescale 1ns/1ps
module urt_rx_timeout_dma (
    // Clock and reset
    input  wire logic                         clk_i,
    input  wire logic                         rst_b_i,
    // Register port
    input  wire urt_pkg::urt_bus_req_t        bus_i,
    output logic      [urt_pkg::DATA_W-1:0]   rdata_o,
    // Receiver and pins
    input  wire logic                         rx_valid_i,
    input  wire logic [urt_pkg::BYTE_W-1:0]   rx_data_i,
    input  wire logic                         cts_b_i,
    input  wire logic [urt_pkg::CNT_W-1:0]    tx_fill_i,
    // Requests
    output logic                              rx_dma_req_o,
    output logic                              tx_dma_req_o,
    output logic                              irq_o
);
    import urt_pkg::*;

    logic [PTR_W-1:0]     wr_ptr_q, rd_ptr_q, rd_ptr_d;
    logic [CNT_W-1:0]     count_q, tick_cnt_q;
    logic [BYTE_W-1:0]    mem_rdata, to_low_q, to_high_q;
    logic [DATA_W-1:0]    tlr_q, feat_q, mask_q, rdata_d;
    logic [DATA_W-1:0]    cnt_q;
    logic [N_EVENTS-1:0]  stat_q, ev;
    logic                 tick_q, to_pend_q, oe_q, cts_s1_q, cts_s2_q;
    logic                 rx_trig_q, tx_trig_q;
    logic                 empty, full, push, pop, periodic, active, expire;
    logic                 rd_iir, rd_stat, rd_lsr, cfg_wr, rx_trig, tx_trig;
    logic [DATA_W-1:0]    reload;
    logic [CNT_W-1:0]     rx_lvl, tx_lvl;

    assign empty    = (count_q == '0);
    assign full     = (count_q == FIFO_DEPTH);
    assign push     = rx_valid_i && !full;
    assign pop      = bus_i.rd && (bus_i.addr == A_RX_HOLDING) && !empty;
    assign rd_iir   = bus_i.rd && (bus_i.addr == A_IRQ_IDENT);
    assign rd_stat  = bus_i.rd && (bus_i.addr == A_IRQ_STAT);
    assign rd_lsr   = bus_i.rd && (bus_i.addr == A_LINE_STAT);
    assign rd_ptr_d = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
    assign reload   = {to_high_q, to_low_q}; // see R1
    assign periodic = feat_q[PERIODIC_BIT]; // see R2
    // Original mode runs only while bytes wait in the FIFO
    assign active   = periodic || !empty; // see R4
    assign expire   = tick_q && active && (reload != '0) && (cnt_q <= TO_LAST);
    assign cfg_wr   = bus_i.wr && ((bus_i.addr == A_TO_LOW) || (bus_i.addr == A_TO_HIGH)
                      || (bus_i.addr == A_FEATURE_TWO));
    // Zero level would always fire; treat as one
    assign rx_lvl   = (tlr_q[TLR_RX_LSB +: CNT_W] == '0) ? LEVEL_MIN
                      : tlr_q[TLR_RX_LSB +: CNT_W];
    assign tx_lvl   = (tlr_q[CNT_W-1:0] == '0) ? LEVEL_MIN : tlr_q[CNT_W-1:0];
    assign rx_trig  = (count_q >= rx_lvl);
    assign tx_trig  = ((FIFO_DEPTH - tx_fill_i) >= tx_lvl);

    urt_fifo_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (push),
        .waddr_i (wr_ptr_q),
        .wdata_i (rx_data_i),
        .raddr_i (rd_ptr_d),
        .rdata_o (mem_rdata)
    );

    // Receive FIFO pointers and fill level
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end else begin
            rd_ptr_q <= rd_ptr_d;
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end

    // Software registers
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            to_low_q  <= TO_RESET;
            to_high_q <= TO_RESET;
            feat_q    <= '0;
            tlr_q     <= TLR_RESET;
            mask_q    <= MASK_RESET;
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                A_TO_LOW:      to_low_q  <= bus_i.wdata[BYTE_W-1:0];
                A_TO_HIGH:     to_high_q <= bus_i.wdata[BYTE_W-1:0];
                A_FEATURE_TWO: feat_q    <= bus_i.wdata;
                A_TRIG_LEVEL:  tlr_q     <= bus_i.wdata; // see R7
                A_IRQ_MASK:    mask_q    <= bus_i.wdata;
                default:       ;
            endcase
        end
    end

    // Microsecond tick for the timeout counter
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            tick_cnt_q <= '0;
            tick_q     <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_CYC - 1'b1);
            if (tick_cnt_q == TICK_CYC - 1'b1) begin
                tick_cnt_q <= '0;
            end else begin
                tick_cnt_q <= tick_cnt_q + 1'b1;
            end
        end
    end

    // Timeout counter; data traffic restarts it only in original mode
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cnt_q <= '0;
        end else if (cfg_wr || expire) begin
            cnt_q <= reload; // see R1
        end else if (!periodic && (push || pop)) begin
            cnt_q <= reload; // see R2
        end else if (tick_q && active && (cnt_q != '0)) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Pending timeout: expiry sets, ident read clears, set wins.
    // Other register reads deliberately play no part here.
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            to_pend_q <= 1'b0;
        end else if (expire) begin
            to_pend_q <= 1'b1; // see R5
        end else if (rd_iir) begin
            to_pend_q <= 1'b0; // see R3
        end
    end

    // Sync of the modem pin; resets to its idle high level
    // No logic ahead of stage one; stage one feeds stage two only
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            cts_s1_q <= 1'b1;
            cts_s2_q <= 1'b1;
        end else begin
            cts_s1_q <= cts_b_i;
            cts_s2_q <= cts_s1_q;
        end
    end

    // Overrun flag, cleared by a line status read
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            oe_q <= 1'b0;
        end else if (rx_valid_i && full) begin
            oe_q <= 1'b1;
        end else if (rd_lsr) begin
            oe_q <= 1'b0;
        end
    end

    // DMA requests are levels; edges feed the sticky status
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rx_trig_q <= 1'b0;
            tx_trig_q <= 1'b0;
        end else begin
            rx_trig_q <= rx_trig;
            tx_trig_q <= tx_trig;
        end
    end

    always_comb begin
        ev             = '0;
        ev[ST_TIMEOUT] = expire;
        ev[ST_RX_TRIG] = rx_trig && !rx_trig_q;
        ev[ST_TX_TRIG] = tx_trig && !tx_trig_q;
        ev[ST_OVERRUN] = rx_valid_i && full;
    end

    // Sticky status, read clears, new event wins
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= (rd_stat ? '0 : stat_q) | ev;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_o        <= 1'b0;
            rx_dma_req_o <= 1'b0;
            tx_dma_req_o <= 1'b0;
        end else begin
            irq_o        <= |(stat_q & mask_q[N_EVENTS-1:0]);
            rx_dma_req_o <= rx_trig;
            tx_dma_req_o <= tx_trig;
        end
    end

    // Read data; unmapped addresses read zero
    always_comb begin
        rdata_d = '0;
        case (bus_i.addr)
            A_RX_HOLDING:  rdata_d[BYTE_W-1:0] = empty ? '0 : mem_rdata; // see R8
            A_IRQ_IDENT: begin
                rdata_d[IIR_NONE_BIT] = !to_pend_q;
                rdata_d[IIR_TO_BIT]   = to_pend_q;
            end
            A_TRIG_LEVEL:  rdata_d = tlr_q;
            A_FEATURE_TWO: rdata_d = feat_q;
            A_TO_LOW:      rdata_d[BYTE_W-1:0] = to_low_q;
            A_TO_HIGH:     rdata_d[BYTE_W-1:0] = to_high_q;
            A_LINE_STAT: begin
                rdata_d[LSR_DR_BIT] = !empty;
                rdata_d[LSR_OE_BIT] = oe_q;
            end
            A_MODEM_STAT:  rdata_d[0] = !cts_s2_q;
            A_IRQ_STAT:    rdata_d[N_EVENTS-1:0] = stat_q;
            A_IRQ_MASK:    rdata_d = mask_q;
            default:       rdata_d = '0;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (bus_i.rd) begin
            rdata_o <= rdata_d;
        end else begin
            rdata_o <= '0;
        end
    end

    property p_expire_sets;
        @(posedge clk_i) disable iff (!rst_b_i)
        expire |=> to_pend_q && stat_q[ST_TIMEOUT];
    endproperty
    a_expire_sets: assert property (p_expire_sets) else $error("expiry lost"); // see R1

    property p_iir_clear;
        @(posedge clk_i) disable iff (!rst_b_i)
        (rd_iir && !expire) |=> !to_pend_q;
    endproperty
    a_iir_clear: assert property (p_iir_clear) else $error("ident read kept timeout"); // see R3

    property p_other_reads;
        @(posedge clk_i) disable iff (!rst_b_i)
        (bus_i.rd && !expire && ((bus_i.addr == A_RX_HOLDING) || (bus_i.addr == A_LINE_STAT)
            || (bus_i.addr == A_MODEM_STAT))) |=> (to_pend_q == $past(to_pend_q));
    endproperty
    a_other_reads: assert property (p_other_reads) else $error("read changed timeout"); // see R8

    property p_orig_idle;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!periodic && empty && !cfg_wr && !push) |=> $stable(cnt_q);
    endproperty
    a_orig_idle: assert property (p_orig_idle) else $error("idle expiry"); // see R2

    property p_orig_restart;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!periodic && push && !cfg_wr) |=> (cnt_q == reload);
    endproperty
    a_orig_restart: assert property (p_orig_restart) else $error("no restart"); // see R4

    property p_periodic_rearm;
        @(posedge clk_i) disable iff (!rst_b_i)
        (expire && periodic) |=> (cnt_q == $past(reload)) ##1 !expire;
    endproperty
    a_periodic_rearm: assert property (p_periodic_rearm) else $error("no rearm"); // see R5

    property p_rx_dma;
        @(posedge clk_i) disable iff (!rst_b_i)
        ((count_q != '0) && (count_q >= tlr_q[TLR_RX_LSB +: CNT_W])) |=> rx_dma_req_o;
    endproperty
    a_rx_dma: assert property (p_rx_dma) else $error("rx request missing"); // see R7

    property p_irq_level;
        @(posedge clk_i) disable iff (!rst_b_i)
        (expire && mask_q[ST_TIMEOUT] && !(bus_i.wr && (bus_i.addr == A_IRQ_MASK)))
            |=> ##1 irq_o;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq missing"); // see R1

    property p_pop_count;
        @(posedge clk_i) disable iff (!rst_b_i)
        (pop && !push) |=> (count_q == $past(count_q) - 1'b1);
    endproperty
    a_pop_count: assert property (p_pop_count) else $error("pop miscount"); // see R4

    c_periodic: cover property (@(posedge clk_i) disable iff (!rst_b_i) expire && periodic);
    c_original: cover property (@(posedge clk_i) disable iff (!rst_b_i) expire && !periodic);
    c_clear:    cover property (@(posedge clk_i) disable iff (!rst_b_i) rd_iir && to_pend_q);
    c_rx_dma:   cover property (@(posedge clk_i) disable iff (!rst_b_i) rx_trig && !rx_trig_q);
endmodule : urt_rx_timeout_dma

// File: tb/urt_dma_model.sv
/*
 * DMA reader model: drains the receive holding register in bursts.
 * Assumes the bench hands it the bus only while en_i is high.
 */
`timescale 1ns/1ps
module urt_dma_model (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_b_i,
    // Bench control
    input  wire logic                        en_i,
    input  wire logic [5:0]                  burst_i,
    // Block side
    input  wire logic                        req_i,
    input  wire logic [urt_pkg::DATA_W-1:0]  rdata_i,
    output urt_pkg::urt_bus_req_t            bus_o,
    // Observed traffic
    output int                               pops_o,
    output logic      [urt_pkg::BYTE_W-1:0]  last_o
);
    import urt_pkg::*;

    // One read at a time; slower than pipelined but still legal.
    // One process owns every output, so nothing has two drivers.
    initial begin
        bus_o  = '0;
        pops_o = 0;
        last_o = '0;
        forever begin
            @(posedge clk_i);
            if (rst_b_i && en_i && req_i) begin
                for (int i = 0; i < int'(burst_i); i++) begin
                    bus_o.rd   <= 1'b1;
                    bus_o.addr <= A_RX_HOLDING;
                    @(posedge clk_i);
                    bus_o.rd   <= 1'b0;
                    @(negedge clk_i);
                    last_o = rdata_i[BYTE_W-1:0];
                    pops_o = pops_o + 1;
                    @(posedge clk_i);
                end
                // Request lags the fill by a cycle
                repeat (2) @(posedge clk_i);
            end
        end
    end
endmodule : urt_dma_model

// File: tb/urt_rx_timeout_dma_tb.sv
/*
 * Self-checking bench of the receive timeout and DMA trigger block.
 * Assumes the package and the DMA reader model are compiled first.
 */
`timescale 1ns/1ps
module urt_rx_timeout_dma_tb;
    import urt_pkg::*;

    logic                clk_i;
    logic                rst_b_i;
    urt_bus_req_t        tb_bus;
    urt_bus_req_t        dma_bus;
    urt_bus_req_t        bus_i;
    logic [DATA_W-1:0]   rdata_o;
    logic                rx_valid_i;
    logic [BYTE_W-1:0]   rx_data_i;
    logic                cts_b_i;
    logic [CNT_W-1:0]    tx_fill_i;
    logic                rx_dma_req_o;
    logic                tx_dma_req_o;
    logic                irq_o;
    logic                dma_on;
    int                  dma_pops;
    logic [BYTE_W-1:0]   dma_last;
    int                  err_total;
    int                  tests_run;

    assign bus_i = dma_on ? dma_bus : tb_bus;

    urt_rx_timeout_dma uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rdata_o(rdata_o),
        .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .cts_b_i(cts_b_i),
        .tx_fill_i(tx_fill_i), .rx_dma_req_o(rx_dma_req_o),
        .tx_dma_req_o(tx_dma_req_o), .irq_o(irq_o));

    urt_dma_model dma (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .en_i(dma_on), .burst_i(6'h04),
        .req_i(rx_dma_req_o), .rdata_i(rdata_o), .bus_o(dma_bus),
        .pops_o(dma_pops), .last_o(dma_last));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_i);
        tb_bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        tb_bus <= '0;
    endtask : reg_wr

    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_i);
        tb_bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_i);
        tb_bus <= '0;
        @(negedge clk_i);
        check(rdata_o, exp);
    endtask : reg_rd

    task automatic push(input logic [BYTE_W-1:0] b);
        @(posedge clk_i);
        rx_valid_i <= 1'b1;
        rx_data_i  <= b;
        @(posedge clk_i);
        rx_valid_i <= 1'b0;
        rx_data_i  <= ~b;
    endtask : push

    // Bounded wait, then the level itself is compared
    task automatic wait_irq(input logic lvl, input int lim);
        int n;
        n = 0;
        while (irq_o !== lvl && n < lim) begin
            @(negedge clk_i);
            n++;
        end
        check({15'h0000, irq_o}, {15'h0000, lvl});
    endtask : wait_irq

    task automatic give_verdict;
        if (err_total == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        give_verdict();
    end

    initial begin
        int i;
        rst_b_i = 1'b0;
        tb_bus = '0;
        rx_valid_i = 1'b0;
        rx_data_i = 8'h00;
        cts_b_i = 1'b1;
        tx_fill_i = 6'h00;
        dma_on = 1'b0;
        err_total = 0;
        tests_run = 0;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        reg_rd(A_IRQ_IDENT, 16'h0001);
        reg_rd(A_TRIG_LEVEL, TLR_RESET);
        reg_rd(4'hF, 16'h0000);
        reg_rd(A_IRQ_STAT, 16'h0004);
        // Original mode: empty FIFO holds the count
        reg_wr(A_IRQ_MASK, 16'h0001);
        reg_wr(A_TO_HIGH, 16'h0000);
        reg_wr(A_TO_LOW, 16'h0002);
        repeat (200) @(negedge clk_i);
        check({15'h0000, irq_o}, 16'h0000);
        push(8'h5A);
        wait_irq(1'b1, 200);
        reg_rd(A_IRQ_STAT, 16'h0003);
        wait_irq(1'b0, 3);
        reg_rd(A_IRQ_IDENT, 16'h0002);
        reg_rd(A_IRQ_IDENT, 16'h0001);
        wait_irq(1'b1, 200);
        reg_rd(A_LINE_STAT, 16'h0001);
        reg_rd(A_MODEM_STAT, 16'h0000);
        reg_rd(A_RX_HOLDING, 16'h005A);
        reg_rd(A_IRQ_IDENT, 16'h0002);
        reg_rd(A_IRQ_STAT, 16'h0001);
        reg_rd(A_IRQ_IDENT, 16'h0001);
        repeat (200) @(negedge clk_i);
        check({15'h0000, irq_o}, 16'h0000);
        // Periodic mode fires with no data at all
        reg_wr(A_FEATURE_TWO, 16'h0040);
        wait_irq(1'b1, 200);
        reg_rd(A_IRQ_IDENT, 16'h0002);
        reg_rd(A_IRQ_STAT, 16'h0001);
        wait_irq(1'b0, 3);
        wait_irq(1'b1, 200);
        reg_rd(A_IRQ_IDENT, 16'h0002);
        reg_rd(A_IRQ_STAT, 16'h0001);
        reg_rd(A_FEATURE_TWO, 16'h0040);
        reg_wr(A_FEATURE_TWO, 16'h0000);
        repeat (200) @(negedge clk_i);
        check({15'h0000, irq_o}, 16'h0000);
        reg_rd(A_IRQ_IDENT, 16'h0001);
        // DMA service at power-of-two levels
        reg_wr(A_TRIG_LEVEL, 16'h0408);
        reg_wr(A_FEATURE_TWO, 16'h0040);
        tx_fill_i <= 6'h18;
        for (i = 0; i < 3; i++) begin
            push(8'hA0 + 8'(i));
        end
        repeat (3) @(negedge clk_i);
        check({14'h0000, rx_dma_req_o, tx_dma_req_o}, 16'h0001);
        @(posedge clk_i);
        tx_fill_i <= 6'h19;
        push(8'hA3);
        repeat (3) @(negedge clk_i);
        check({14'h0000, rx_dma_req_o, tx_dma_req_o}, 16'h0002);
        for (i = 4; i < 8; i++) begin
            push(8'hA0 + 8'(i));
        end
        @(posedge clk_i);
        dma_on <= 1'b1;
        repeat (60) @(posedge clk_i);
        dma_on <= 1'b0;
        @(negedge clk_i);
        check(16'(dma_pops), 16'h0008);
        check({8'h00, dma_last}, 16'h00A7);
        check({15'h0000, rx_dma_req_o}, 16'h0000);
        // Overrun: one byte beyond a full FIFO
        for (i = 0; i < 33; i++) begin
            push(8'(i));
        end
        reg_rd(A_LINE_STAT, 16'h0003);
        reg_rd(A_LINE_STAT, 16'h0001);
        @(posedge clk_i);
        cts_b_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        reg_rd(A_MODEM_STAT, 16'h0001);
        give_verdict();
    end
endmodule : urt_rx_timeout_dma_tb
